// file: drs_host_model.sv
// Host serial master model for the link pins
`timescale 1ns/100ps
module drs_host_model (
  // Link pins
  output logic sclk,
  output logic csN,
  output logic sdi
);
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    sdi = 1'b1;
  end
  // ------------------------------
  // One frame of whole words
  // ------------------------------
  task automatic sendFrame(input logic [23:0] w [$]);
    #2.5;
    csN = 1'b0;
    foreach (w[k]) begin
      for (int i = 23; i >= 0; i--) begin
        sdi = w[k][i];
        #15 sclk = 1'b1;
        #15 sclk = 1'b0;
      end
    end
    #15 csN = 1'b1;
    // Released line shows the inverse
    sdi = ~sdi;
  endtask
endmodule

// file: drs_pkg.sv
// Shared constants and types for the channel refresh sequencer
package drs_pkg;

  // ---------------------------------------------------------------
  // Channel memory
  // ---------------------------------------------------------------
  localparam int CHANNELS = 16;
  localparam int CODE_W = 16;
  localparam int ADDR_W = 4;
  localparam logic [3:0] LAST_CHANNEL = 4'hf;
  localparam logic [15:0] RESET_CODE = 16'h4f2c;

  // ---------------------------------------------------------------
  // Serial word layout, most significant bit first
  // ---------------------------------------------------------------
  localparam int WORD_W = 24;
  localparam logic [4:0] WORD_LAST_BIT = 5'h17;
  localparam int CODE_MSB = 23;
  localparam int CODE_LSB = 8;
  localparam int ADDR_MSB = 7;
  localparam int ADDR_LSB = 4;
  localparam int UPDATE_MODE_POS = 2;
  localparam int CLOCK_SOURCE_POS = 1;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int CHANNEL_SLOT_NS = 20000;
  localparam int SEQ_CYCLES_PER_SLOT = 2;
  localparam int SEQ_PERIOD_NS = CHANNEL_SLOT_NS / SEQ_CYCLES_PER_SLOT;
  localparam int INT_TICK_CYCLES = SEQ_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_CNT_W = 11;
  localparam logic [10:0] INT_TICK_LAST = 11'(INT_TICK_CYCLES - 1);
  localparam logic [1:0] EXT_DIV_LAST = 2'h3;

  // ---------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SEQ_LOAD,
    SEQ_SAMPLE,
    SEQ_HALT
  } drs_state_t;

endpackage

// file: drs_sequencer.sv
// Refresh sequencer, channel memory and update control
`timescale 1ns/100ps
module drs_sequencer
  import drs_pkg::*;
(
  // System
  input wire logic clk,
  input wire logic sys_rst,
  // Serial link
  input wire logic sclk,
  input wire logic csN,
  input wire logic sdi,
  // Mode, clock and reset pins
  input wire logic immediateSelectPin,
  input wire logic clockSourcePin,
  input wire logic externalSequencerClock,
  input wire logic rstN,
  // Converter and sample-and-hold
  output logic [drs_pkg::CODE_W-1:0] dacCode,
  output logic dacLoad,
  output logic shaStrobe,
  output logic [drs_pkg::ADDR_W-1:0] shaChannel,
  // Status
  output logic resetBusy,
  output logic extClockActive,
  output logic immediateActive,
  output logic halted
);
  import drs_pkg::*;

  // ---------------------------------------------------------------
  // Link side receiver
  // ---------------------------------------------------------------
  drs_word_if wordBus ();

  drs_serial_rx u_rx (
    .sclk (sclk),
    .csN  (csN),
    .sdi  (sdi),
    .word (wordBus.rx)
  );

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  localparam int PIN_N = 5;
  localparam logic [4:0] PIN_RESET = 5'h11;

  logic [PIN_N-1:0] pinRaw;
  logic [PIN_N-1:0] pinMeta_q;
  logic [PIN_N-1:0] pinSync_q;

  assign pinRaw = {rstN, externalSequencerClock, clockSourcePin,
                   immediateSelectPin, csN};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          pinMeta_q[gi] <= PIN_RESET[gi];
          pinSync_q[gi] <= PIN_RESET[gi];
        end else begin
          pinMeta_q[gi] <= pinRaw[gi];
          pinSync_q[gi] <= pinMeta_q[gi];
        end
      end
    end
  endgenerate

  wire csLow = ~pinSync_q[0];
  wire immPinS = pinSync_q[1];
  wire clkPinS = pinSync_q[2];
  wire eclkS = pinSync_q[3];
  wire rstPinLow = ~pinSync_q[4];

  // ---------------------------------------------------------------
  // Word toggle crossing
  // ---------------------------------------------------------------
  logic togMeta_q;
  logic togSync_q;
  logic togSeen_q;

  always_ff @(posedge clk) begin
    togMeta_q <= wordBus.wordToggle;
    togSync_q <= togMeta_q;
    togSeen_q <= togSync_q;
  end

  wire newWord = togSync_q ^ togSeen_q;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  drs_state_t state_q;
  drs_state_t state_d;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic resetPass_q;
  logic resetPass_d;
  logic immPend_q;
  logic [ADDR_W-1:0] immAddr_q;
  logic updBit_q;
  logic clkSrcBit_q;
  logic [TICK_CNT_W-1:0] intCnt_q;
  logic [1:0] extDiv_q;
  logic eclkPrev_q;
  logic [CODE_W-1:0] mem [CHANNELS];

  // ---------------------------------------------------------------
  // Word fields
  // ---------------------------------------------------------------
  // field decode
  wire [CODE_W-1:0] wCode = wordBus.wordData[CODE_MSB:CODE_LSB];
  wire [ADDR_W-1:0] wAddr = wordBus.wordData[ADDR_MSB:ADDR_LSB];
  wire wUpd = wordBus.wordData[UPDATE_MODE_POS];
  wire wClk = wordBus.wordData[CLOCK_SOURCE_POS];

  wire wordTake = newWord & ~resetPass_q;
  wire wordImm = immPinS | wUpd;
  wire immMode = immPinS | updBit_q;

  // ---------------------------------------------------------------
  // Sequencer clock selection
  // ---------------------------------------------------------------
  // external clock select
  wire useExt = ~resetPass_q & (clkSrcBit_q | clkPinS);
  wire oscOff = clkPinS & ~resetPass_q;
  wire intTick = ~oscOff & (intCnt_q == INT_TICK_LAST);
  wire eclkRise = eclkS & ~eclkPrev_q;
  wire extTick = eclkRise & (extDiv_q == EXT_DIV_LAST);
  wire seqTick = useExt ? extTick : intTick;

  always_ff @(posedge clk) begin
    if (sys_rst || rstPinLow || oscOff || intTick) begin
      intCnt_q <= '0;
    end else begin
      intCnt_q <= intCnt_q + 11'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      eclkPrev_q <= 1'b0;
      extDiv_q <= 2'h0;
    end else begin
      eclkPrev_q <= eclkS;
      if (eclkRise) begin
        extDiv_q <= extDiv_q + 2'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Step decode
  // ---------------------------------------------------------------
  wire haltReq = (csLow | immPend_q) & ~resetPass_q;
  wire inLoad = (state_q == SEQ_LOAD);
  wire inSample = (state_q == SEQ_SAMPLE);
  wire inHalt = (state_q == SEQ_HALT);
  wire doLoad = seqTick & inLoad & ~haltReq;
  wire doSample = seqTick & inSample;
  wire doImm = seqTick & inHalt & ~csLow & immPend_q;
  wire passEnd = doSample & resetPass_q & (addr_q == LAST_CHANNEL);

  // ---------------------------------------------------------------
  // Channel memory
  // ---------------------------------------------------------------
  // reset code written
  wire rstWrite = doLoad & resetPass_q;
  wire memWe = wordTake | rstWrite;
  wire [ADDR_W-1:0] memWa = rstWrite ? addr_q : wAddr;
  wire [CODE_W-1:0] memWd = rstWrite ? RESET_CODE : wCode;
  wire [CODE_W-1:0] seqCode = resetPass_q ? RESET_CODE : mem[addr_q];

  always_ff @(posedge clk) begin
    if (memWe) begin
      mem[memWa] <= memWd;
    end
  end

  // ---------------------------------------------------------------
  // Latched control bits and pending immediate update
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst || rstPinLow) begin
      updBit_q <= 1'b0;
      clkSrcBit_q <= 1'b0;
      immPend_q <= 1'b0;
      immAddr_q <= '0;
    end else if (wordTake) begin
      updBit_q <= wUpd;
      clkSrcBit_q <= wClk;
      if (wordImm) begin
        immPend_q <= 1'b1;
        immAddr_q <= wAddr;
      end else if (doImm) begin
        immPend_q <= 1'b0;
      end
    end else if (doImm) begin
      immPend_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    resetPass_d = resetPass_q;
    unique case (state_q)
      SEQ_LOAD: begin
        if (seqTick && haltReq) begin
          state_d = SEQ_HALT;
        end else if (seqTick) begin
          state_d = SEQ_SAMPLE;
        end
      end
      SEQ_SAMPLE: begin
        if (seqTick && haltReq) begin
          state_d = SEQ_HALT;
        end else if (seqTick) begin
          addr_d = addr_q + 4'h1;
          state_d = SEQ_LOAD;
          if (passEnd) begin
            resetPass_d = 1'b0;
          end
        end
      end
      SEQ_HALT: begin
        if (!csLow && !immPend_q) begin
          state_d = SEQ_LOAD;
        end else if (doImm) begin
          state_d = SEQ_LOAD;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst || rstPinLow) begin
      state_q <= SEQ_LOAD;
      addr_q <= '0;
      resetPass_q <= 1'b1;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      resetPass_q <= resetPass_d;
    end
  end

  // ---------------------------------------------------------------
  // Converter and sample-and-hold drive
  // ---------------------------------------------------------------
  logic [CODE_W-1:0] dacCode_q;
  logic dacLoad_q;
  logic shaStrobe_q;
  logic [ADDR_W-1:0] shaChannel_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dacCode_q <= RESET_CODE;
      dacLoad_q <= 1'b0;
      shaStrobe_q <= 1'b0;
      shaChannel_q <= '0;
    end else begin
      dacLoad_q <= doLoad | doImm;
      shaStrobe_q <= doSample | doImm;
      if (doImm) begin
        dacCode_q <= mem[immAddr_q];
        shaChannel_q <= immAddr_q;
      end else if (doLoad) begin
        dacCode_q <= seqCode;
        shaChannel_q <= addr_q;
      end else if (doSample) begin
        shaChannel_q <= addr_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // Status
  // ---------------------------------------------------------------
  logic resetBusy_q;
  logic extClockActive_q;
  logic immediateActive_q;
  logic halted_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      resetBusy_q <= 1'b1;
      extClockActive_q <= 1'b0;
      immediateActive_q <= 1'b0;
      halted_q <= 1'b0;
    end else begin
      resetBusy_q <= resetPass_q;
      extClockActive_q <= useExt;
      immediateActive_q <= immMode;
      halted_q <= inHalt;
    end
  end

  assign dacCode = dacCode_q;
  assign dacLoad = dacLoad_q;
  assign shaStrobe = shaStrobe_q;
  assign shaChannel = shaChannel_q;
  assign resetBusy = resetBusy_q;
  assign extClockActive = extClockActive_q;
  assign immediateActive = immediateActive_q;
  assign halted = halted_q;
endmodule

// file: drs_sequencer_asserts.sv
// Port checks for the refresh sequencer
`timescale 1ns/100ps
module drs_sequencer_asserts
  import drs_pkg::*;
(
  // System
  input wire logic clk,
  input wire logic sys_rst,
  // Pins
  input wire logic csN,
  input wire logic rstN,
  input wire logic externalSequencerClock,
  // Outputs
  input wire logic [drs_pkg::CODE_W-1:0] dacCode,
  input wire logic dacLoad,
  input wire logic shaStrobe,
  input wire logic [drs_pkg::ADDR_W-1:0] shaChannel,
  input wire logic resetBusy,
  input wire logic extClockActive,
  input wire logic immediateActive,
  input wire logic halted
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [3:0] lastCh_q;
  logic haltSeen_q, eclkOld_q;
  logic [4:0] eclkCnt_q;
  wire seqLoad = dacLoad && !shaStrobe;
  wire immUpd = dacLoad && shaStrobe;
  wire immWait = csN && halted && immediateActive && extClockActive;
  wire eclkRise = externalSequencerClock && !eclkOld_q;
  // ------------------------------
  // Helper state
  // ------------------------------
  always_ff @(posedge clk) begin
    eclkOld_q <= externalSequencerClock;
    if (sys_rst || !rstN) begin
      lastCh_q <= 4'hf;
      haltSeen_q <= 1'b0;
    end else if (seqLoad) begin
      lastCh_q <= shaChannel;
      haltSeen_q <= 1'b0;
    end else if (halted) begin
      haltSeen_q <= 1'b1;
    end
    if (sys_rst || immUpd) begin
      eclkCnt_q <= 5'h00;
    end else if (immWait && eclkRise) begin
      eclkCnt_q <= eclkCnt_q + 5'h01;
    end
  end
  load_frozen_a: assert property (
    (!csN)[*5] ##0 !resetBusy |-> !dacLoad && $stable(dacCode))
    else $error("load while frame open");
  settle_gap_a: assert property (
    seqLoad |=> (!shaStrobe && !dacLoad)[*8])
    else $error("strobe too soon after load");
  chan_step_a: assert property (
    seqLoad && rstN |-> shaChannel == lastCh_q + 4'h1
      || (haltSeen_q && shaChannel == lastCh_q))
    else $error("scan address out of order");
  strobe_chan_a: assert property (
    shaStrobe && !dacLoad && rstN |->
      shaChannel == lastCh_q && $stable(dacCode))
    else $error("strobe channel differs from load");
  reset_code_a: assert property (
    resetBusy && dacLoad |-> dacCode == RESET_CODE)
    else $error("reset pass code wrong");
  reset_run_a: assert property (
    resetBusy |-> !halted)
    else $error("reset pass interrupted");
  imm_late_a: assert property (
    immUpd |-> csN && $past(csN, 2))
    else $error("immediate update with frame open");
  imm_bound_a: assert property (
    eclkCnt_q <= 5'h0a)
    else $error("immediate update too late");
endmodule

// file: drs_serial_rx.sv
// Serial word receiver running on the host's serial clock
`timescale 1ns/100ps
module drs_serial_rx
  import drs_pkg::*;
(
  // Link pins
  input wire logic sclk,
  input wire logic csN,
  input wire logic sdi,
  // Word out
  drs_word_if.rx word
);
  import drs_pkg::*;

  logic [4:0] bitCnt_q;
  logic [22:0] shift_q;
  logic toggle_q = 1'b0;
  logic [23:0] word_q = '0;
  wire lastBit = (bitCnt_q == WORD_LAST_BIT);

  // ---------------------------------------------------------------
  // Bit counter, cleared while the frame is closed
  // ---------------------------------------------------------------
  // framed 24-bit words
  always_ff @(posedge sclk or posedge csN) begin
    if (csN) begin
      bitCnt_q <= 5'h00;
    end else if (lastBit) begin
      bitCnt_q <= 5'h00;
    end else begin
      bitCnt_q <= bitCnt_q + 5'h01;
    end
  end

  // ---------------------------------------------------------------
  // Shift in MSB first, publish whole words with a toggle
  // ---------------------------------------------------------------
  // MSB first shift
  always_ff @(posedge sclk) begin
    shift_q <= {shift_q[21:0], sdi};
    if (!csN && lastBit) begin
      word_q <= {shift_q, sdi};
      toggle_q <= ~toggle_q;
    end
  end

  assign word.wordToggle = toggle_q;
  assign word.wordData = word_q;
endmodule

// file: drs_word_if.sv
// Received serial word handed from the link domain to the sequencer
`timescale 1ns/100ps
interface drs_word_if;
  logic wordToggle;
  logic [23:0] wordData;

  modport rx (
    output wordToggle,
    output wordData
  );

  modport seq (
    input wordToggle,
    input wordData
  );
endinterface

// file: tb_dac_refresh_sequencer.sv
// Self-checking bench for the refresh sequencer
`timescale 1ns/100ps
module tb_dac_refresh_sequencer;
  import drs_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic immPin = 1'b0;
  logic srcPin = 1'b1;
  logic external_sequencer_clock = 1'b0;
  logic rstN = 1'b1;
  logic eclkRun = 1'b0;
  logic [2:0] eDiv = 3'h0;
  wire sclk, csN, sdi;
  logic [15:0] dacCode;
  logic [3:0] shaChannel;
  logic dacLoad, shaStrobe, resetBusy, extClockActive;
  logic immediateActive, halted;
  logic [15:0] shadow [16];
  logic [23:0] q [$];
  int errors = 0, compares = 0, cyc = 0, strobes = 0, t0, t1;
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (shaStrobe === 1'b1) begin
      shadow[shaChannel] <= dacCode;
      strobes <= strobes + 1;
    end
    if (eclkRun) begin
      eDiv <= (eDiv == 3'h4) ? 3'h0 : eDiv + 3'h1;
      if (eDiv == 3'h4) external_sequencer_clock <= ~external_sequencer_clock;
    end
  end
  drs_host_model host (.sclk(sclk), .csN(csN), .sdi(sdi));
  drs_sequencer DUT (.clk(clk), .sys_rst(sys_rst), .sclk(sclk),
    .csN(csN), .sdi(sdi), .immediateSelectPin(immPin),
    .clockSourcePin(srcPin), .externalSequencerClock(external_sequencer_clock),
    .rstN(rstN), .dacCode(dacCode), .dacLoad(dacLoad),
    .shaStrobe(shaStrobe), .shaChannel(shaChannel),
    .resetBusy(resetBusy), .extClockActive(extClockActive),
    .immediateActive(immediateActive), .halted(halted));
  // ------------------------------
  // Checks and waits
  // ------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic waitEv(input logic [3:0] ch, input logic imm,
      input int lim, output int t);
    int n;
    n = 0;
    do begin
      step(1);
      n++;
    end while (!(dacLoad === 1'b1 && shaStrobe === imm
      && shaChannel === ch) && n < lim);
    t = cyc;
    check(16'(n < lim), 16'h0001);
  endtask
  task automatic waitPass(output int n);
    n = 0;
    while (resetBusy !== 1'b0 && n < 41000) begin
      step(1);
      n++;
    end
  endtask
  // clock-source bit set in every word
  function automatic logic [23:0] mk(input logic [15:0] c,
      input logic [3:0] a, input logic u);
    return {c, a, 1'b0, u, 1'b1, 1'b0};
  endfunction
  task automatic end_of_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #760000;
    errors++;
    $display("Error at %0t: watchdog expired", $time);
    end_of_test;
  end
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    waitPass(t0);
    check(16'(t0 > 39900 && t0 < 40100), 16'h0001);
    step(300);
    check(16'(strobes), 16'h0010);
    foreach (shadow[i]) check(shadow[i], RESET_CODE);
    $display("test reset pass done");
    eclkRun <= 1'b1;
    waitEv(4'h0, 1'b0, 2000, t0);
    waitEv(4'h0, 1'b0, 2000, t1);
    check(16'(t1 - t0), 16'h0500);
    check(16'(extClockActive), 16'h0001);
    $display("test external scan done");
    @(posedge clk);
    srcPin <= 1'b0;
    q = '{mk(16'h1111, 4'h3, 1'b0), mk(16'h2222, 4'h9, 1'b0),
      mk(16'h3333, 4'hf, 1'b0)};
    host.sendFrame(q);
    step(1340);
    check(shadow[3], 16'h1111);
    check(shadow[9], 16'h2222);
    check(shadow[15], 16'h3333);
    check(shadow[4], RESET_CODE);
    check(16'(immediateActive), 16'h0000);
    check(16'(extClockActive), 16'h0001);
    $display("test burst done");
    q = '{mk(16'h5a5a, 4'hc, 1'b1)};
    host.sendFrame(q);
    waitEv(4'hc, 1'b1, 200, t0);
    check(dacCode, 16'h5a5a);
    check(16'(immediateActive), 16'h0001);
    @(posedge clk);
    immPin <= 1'b1;
    step(4);
    q = '{mk(16'hc3c3, 4'h5, 1'b0)};
    host.sendFrame(q);
    waitEv(4'h5, 1'b1, 200, t0);
    check(dacCode, 16'hc3c3);
    $display("test immediate done");
    @(posedge clk);
    immPin <= 1'b0;
    srcPin <= 1'b1;
    rstN <= 1'b0;
    repeat (8) @(posedge clk);
    rstN <= 1'b1;
    step(4);
    check(16'(resetBusy), 16'h0001);
    q = '{mk(16'h7777, 4'h2, 1'b0)};
    host.sendFrame(q);
    waitPass(t0);
    step(1400);
    foreach (shadow[i]) check(shadow[i], RESET_CODE);
    $display("test reset pin done");
    end_of_test;
  end
endmodule
bind drs_sequencer drs_sequencer_asserts chk (.clk(clk),
  .sys_rst(sys_rst), .csN(csN), .rstN(rstN),
  .externalSequencerClock(externalSequencerClock), .dacCode(dacCode),
  .dacLoad(dacLoad), .shaStrobe(shaStrobe), .shaChannel(shaChannel),
  .resetBusy(resetBusy), .extClockActive(extClockActive),
  .immediateActive(immediateActive), .halted(halted));
